// ### hw/flash_prot_pkg.sv
/*
 * Constants and types for the one-time region and sector protection command block.
 * Assumes a 250 MHz core clock that oversamples the serial interface pins.
 */
package flash_prot_pkg;
	localparam logic [7:0] WRITE_ENABLE_CMD = 8'h06;
	localparam logic [7:0] STATUS_ONE_READ_CMD = 8'h05;
	localparam logic [7:0] ONETIME_PROGRAM_CMD = 8'h42;
	localparam logic [7:0] ONETIME_READ_CMD = 8'h4B;
	localparam logic [7:0] PROT_CONFIG_READ_CMD = 8'h2B;
	localparam logic [7:0] PROT_CONFIG_PROGRAM_CMD = 8'h2F;
	localparam logic [7:0] VOLATILE_LOCK_READ_CMD = 8'hE0;
	localparam logic [7:0] VOLATILE_LOCK_WRITE_CMD = 8'hE1;
	localparam logic [7:0] PERSISTENT_LOCK_READ_CMD = 8'hE2;
	localparam logic [7:0] PERSISTENT_LOCK_PROGRAM_CMD = 8'hE3;
	localparam logic [7:0] PERSISTENT_LOCK_ERASE_CMD = 8'hE4;
	localparam logic [7:0] ERASE_SUSPEND_CMD = 8'h75;
	localparam int OTP_BYTES = 1024;
	localparam int OTP_ADDR_W = 10;
	localparam int PAGE_BYTES = 16;
	localparam int SECTORS = 256;
	localparam int SECTOR_W = 8;
	localparam int SECTOR_SHIFT = 16;
	localparam logic [15:0] OPCODE_BITS = 16'h0008;
	localparam logic [15:0] HDR_OTP_PROG = 16'h0020;
	localparam logic [15:0] HDR_ADDR_DUMMY = 16'h0028;
	localparam logic [15:0] LEN_PROT_CONFIG = 16'h0018;
	localparam logic [15:0] LEN_VOLATILE_WRITE = 16'h0030;
	localparam logic [15:0] LEN_PERSISTENT_PROG = 16'h0028;
	localparam logic [5:0] ADDR_BITS_OTP = 6'h18;
	localparam logic [5:0] ADDR_BITS_SECTOR = 6'h20;
	localparam int WIP_BIT = 0;
	localparam int WEL_BIT = 1;
	localparam int PERR_BIT = 6;
	localparam logic [15:0] PROT_CONFIG_RESET = 16'hFFFF;
	localparam logic [7:0] LOCK_ERASED = 8'hFF;
	localparam logic [7:0] LOCK_PROGRAMMED = 8'h00;
	localparam logic [7:0] OTP_ERASED = 8'hFF;
	localparam int CLK_PERIOD_PS = 4000;
	localparam int PROGRAM_TIME_NS = 2000;
	localparam int ERASE_TIME_NS = 200000;
	localparam int PROGRAM_CYCLES = (PROGRAM_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int ERASE_CYCLES = (ERASE_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int TIMER_W = 20;

	typedef struct packed {
		logic cs_n;
		logic sck;
		logic si;
		logic otp_lock;
	} pin_t;

	localparam pin_t PIN_IDLE = '{cs_n: 1'b1, sck: 1'b0, si: 1'b0, otp_lock: 1'b0};

	typedef enum logic [2:0] {OP_NONE, OP_OTP, OP_ASP, OP_VOL, OP_PERS, OP_ERASE} op_t;
endpackage

// ### hw/flash_prot_cmds.sv
/*
 * Serial command interpreter for the one-time region and sector protection registers.
 * Assumes SPI mode 0 from the host with SCK well below a quarter of clk_in; pins are oversampled.
 */
// Notes on behaviour
// - one-time program only below byte 1024
// - one-time program framed like page program
// - locked zeros set program error; ones never
// - repeated programs only clear remaining ones
// - one-time read never wraps, reads zero past top
// - one-time read has one fixed dummy byte
// - sample on rising SCK, drive on falling
// - config read low byte first, repeats
// - config program exactly sixteen data bits
// - self-timed write, busy flag, latch clears
// - lock writes update error and busy
// - volatile read sector value repeats every byte
// - lock reads never advance the address
// - volatile write exactly eight data bits
// - persistent read framed like volatile read
// - persistent program ends after address bits
// - persistent erase sets all bits one
// - erase suspend refused during persistent erase
// - write commands need write-enable latch set
`timescale 1ns/100ps
module flash_prot_cmds #(
	parameter int ERASE_CYCLES_P = flash_prot_pkg::ERASE_CYCLES
) (
	input wire logic clk_in, // core clock
	input wire logic rstn_in, // async reset, active low
	input wire logic cs_n_in, // chip select, active low
	input wire logic sck_in, // serial clock from host
	input wire logic si_in, // serial data in
	input wire logic otp_lock_in, // one-time region locked
	output logic so_out, // serial data out
	output logic so_oe_out, // so driven while selected
	output logic busy_out, // self-timed operation running
	output logic suspend_refused_out // pulse: suspend refused
);
	import flash_prot_pkg::*;

	logic [1:0] rst_sync;
	logic rstn;
	pin_t s1, s2, s3, pin, prev;
	logic sck_rise, sck_fall, cs_rise, cs_fall;
	logic [15:0] bit_cnt, hdr, k;
	logic [7:0] opcode, next_byte;
	logic [31:0] addr;
	logic [15:0] data_sr;
	logic [PAGE_BYTES-1:0][7:0] page_buf;
	logic data_byte_done;
	op_t op, next_op;
	logic [TIMER_W-1:0] timer, busy_run;
	logic [31:0] op_addr;
	logic [15:0] op_data;
	logic frame_ok, accept, done, write_enable_latch, p_err, otp_err, rd_bit;
	logic [7:0] status_byte;
	logic [13:0] otp_sum;
	logic [15:0] prot_config;
	logic [7:0] otp_mem [OTP_BYTES];
	logic [7:0] vol_lock [SECTORS];
	logic [7:0] pers_lock [SECTORS];

	function automatic logic [5:0] addr_bits(input logic [7:0] cmd);
		case (cmd)
			ONETIME_PROGRAM_CMD, ONETIME_READ_CMD: addr_bits = ADDR_BITS_OTP;
			VOLATILE_LOCK_READ_CMD, VOLATILE_LOCK_WRITE_CMD,
			PERSISTENT_LOCK_READ_CMD, PERSISTENT_LOCK_PROGRAM_CMD: addr_bits = ADDR_BITS_SECTOR;
			default: addr_bits = 6'h00;
		endcase
	endfunction
	function automatic logic [15:0] hdr_bits(input logic [7:0] cmd);
		case (cmd)
			ONETIME_PROGRAM_CMD: hdr_bits = HDR_OTP_PROG;
			ONETIME_READ_CMD, VOLATILE_LOCK_READ_CMD, PERSISTENT_LOCK_READ_CMD,
			VOLATILE_LOCK_WRITE_CMD: hdr_bits = HDR_ADDR_DUMMY;
			default: hdr_bits = OPCODE_BITS;
		endcase
	endfunction
	// msb of each byte leaves first
	function automatic logic pick(input logic [7:0] b, input logic [15:0] idx);
		pick = b[3'h7 - idx[2:0]];
	endfunction
	function automatic logic [SECTOR_W-1:0] sector(input logic [31:0] a);
		sector = a[SECTOR_SHIFT +: SECTOR_W];
	endfunction
	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			rst_sync <= 2'h0;
		end else begin
			rst_sync <= {rst_sync[0], 1'b1};
		end
	end
	assign rstn = rst_sync[1];
	// a pin change counts only once two late stages agree
	always_ff @(posedge clk_in or negedge rstn) begin
		if (!rstn) begin
			s1 <= PIN_IDLE;
			s2 <= PIN_IDLE;
			s3 <= PIN_IDLE;
			pin <= PIN_IDLE;
			prev <= PIN_IDLE;
		end else begin
			s1 <= '{cs_n: cs_n_in, sck: sck_in, si: si_in, otp_lock: otp_lock_in};
			s2 <= s1;
			s3 <= s2;
			prev <= pin;
			for (int i = 0; i < 4; i++) begin
				if (s2[i] == s3[i]) begin
					pin[i] <= s3[i];
				end
			end
		end
	end

	assign sck_rise = pin.sck & ~prev.sck & ~pin.cs_n;
	assign sck_fall = ~pin.sck & prev.sck & ~pin.cs_n;
	assign cs_rise = pin.cs_n & ~prev.cs_n;
	assign cs_fall = ~pin.cs_n & prev.cs_n;
	assign hdr = hdr_bits(opcode);
	assign k = bit_cnt - hdr;
	assign next_byte = {data_sr[6:0], pin.si};
	assign data_byte_done = sck_rise && bit_cnt >= hdr && bit_cnt >= OPCODE_BITS && k[2:0] == 3'h7;
	// frame shifter; address never advances for lock reads
	always_ff @(posedge clk_in or negedge rstn) begin
		if (!rstn) begin
			bit_cnt <= 16'h0000;
			opcode <= 8'h00;
			addr <= 32'h0000_0000;
			data_sr <= 16'h0000;
		end else if (cs_fall) begin
			bit_cnt <= 16'h0000;
			opcode <= 8'h00;
			addr <= 32'h0000_0000;
		end else if (sck_rise) begin
			bit_cnt <= (&bit_cnt) ? bit_cnt : bit_cnt + 16'h0001;
			if (bit_cnt < OPCODE_BITS) begin
				opcode <= {opcode[6:0], pin.si};
			end else if (bit_cnt < OPCODE_BITS + 16'(addr_bits(opcode))) begin
				addr <= {addr[30:0], pin.si};
			end else begin
				data_sr <= {data_sr[14:0], pin.si};
			end
		end
	end
	// page buffer collects data bytes; held while a program is pending
	always_ff @(posedge clk_in or negedge rstn) begin
		if (!rstn) begin
			page_buf <= {PAGE_BYTES{OTP_ERASED}};
		end else if (!busy_out && cs_fall) begin
			page_buf <= {PAGE_BYTES{OTP_ERASED}};
		end else if (!busy_out && data_byte_done && opcode == ONETIME_PROGRAM_CMD) begin
			page_buf[4'(addr[3:0] + k[6:3])] <= page_buf[4'(addr[3:0] + k[6:3])] & next_byte;
		end
	end
	always_comb begin
		next_op = OP_NONE;
		frame_ok = 1'b0;
		case (opcode)
			ONETIME_PROGRAM_CMD: begin
				next_op = OP_OTP;
				frame_ok = bit_cnt >= HDR_OTP_PROG + OPCODE_BITS && k[2:0] == 3'h0 && addr[23:OTP_ADDR_W] == 14'h0;
			end
			PROT_CONFIG_PROGRAM_CMD: begin
				next_op = OP_ASP;
				frame_ok = bit_cnt == LEN_PROT_CONFIG;
			end
			VOLATILE_LOCK_WRITE_CMD: begin
				next_op = OP_VOL;
				frame_ok = bit_cnt == LEN_VOLATILE_WRITE;
			end
			PERSISTENT_LOCK_PROGRAM_CMD: begin
				next_op = OP_PERS;
				frame_ok = bit_cnt == LEN_PERSISTENT_PROG;
			end
			PERSISTENT_LOCK_ERASE_CMD: begin
				next_op = OP_ERASE;
				frame_ok = bit_cnt == OPCODE_BITS;
			end
			default: frame_ok = 1'b0;
		endcase
	end

	assign accept = cs_rise && !busy_out && write_enable_latch && frame_ok;
	assign done = busy_out && timer == TIMER_W'(1);
	assign otp_err = pin.otp_lock && !(&page_buf);
	// self-timed engine
	always_ff @(posedge clk_in or negedge rstn) begin
		if (!rstn) begin
			op <= OP_NONE;
			timer <= '0;
			busy_out <= 1'b0;
			op_addr <= 32'h0000_0000;
			op_data <= 16'h0000;
		end else if (accept) begin
			op <= next_op;
			busy_out <= 1'b1;
			timer <= (next_op == OP_ERASE) ? TIMER_W'(ERASE_CYCLES_P) : TIMER_W'(PROGRAM_CYCLES);
			op_addr <= addr;
			op_data <= data_sr;
		end else if (done) begin
			op <= OP_NONE;
			busy_out <= 1'b0;
			timer <= '0;
		end else if (busy_out) begin
			timer <= timer - TIMER_W'(1);
		end
	end
	// latch and error flag; error cleared when the next write starts
	always_ff @(posedge clk_in or negedge rstn) begin
		if (!rstn) begin
			write_enable_latch <= 1'b0;
			p_err <= 1'b0;
		end else begin
			if (cs_rise && !busy_out && bit_cnt == OPCODE_BITS && opcode == WRITE_ENABLE_CMD) begin
				write_enable_latch <= 1'b1;
			end else if (done) begin
				write_enable_latch <= 1'b0;
			end
			if (done && op == OP_OTP && otp_err) begin
				p_err <= 1'b1;
			end else if (accept) begin
				p_err <= 1'b0;
			end
		end
	end
	// storage updates at the end of the self-timed interval
	always_ff @(posedge clk_in or negedge rstn) begin
		if (!rstn) begin
			prot_config <= PROT_CONFIG_RESET;
			for (int i = 0; i < OTP_BYTES; i++) begin
				otp_mem[i] <= OTP_ERASED;
			end
			for (int i = 0; i < SECTORS; i++) begin
				vol_lock[i] <= LOCK_ERASED;
				pers_lock[i] <= LOCK_ERASED;
			end
		end else if (done) begin
			case (op)
				OP_OTP: begin
					if (!otp_err) begin
						for (int i = 0; i < PAGE_BYTES; i++) begin
							otp_mem[{op_addr[OTP_ADDR_W-1:4], 4'(i)}] <= otp_mem[{op_addr[OTP_ADDR_W-1:4], 4'(i)}]
								& page_buf[i];
						end
					end
				end
				OP_ASP: prot_config <= prot_config & {op_data[7:0], op_data[15:8]};
				OP_VOL: vol_lock[sector(op_addr)] <= op_data[7:0];
				OP_PERS: pers_lock[sector(op_addr)] <= LOCK_PROGRAMMED;
				OP_ERASE: begin
					for (int i = 0; i < SECTORS; i++) begin
						pers_lock[i] <= LOCK_ERASED;
					end
				end
				default: prot_config <= prot_config;
			endcase
		end
	end
	assign status_byte = 8'(({7'h00, p_err} << PERR_BIT) | ({7'h00, write_enable_latch} << WEL_BIT) | ({7'h00, busy_out} << WIP_BIT));
	assign otp_sum = {4'h0, addr[OTP_ADDR_W-1:0]} + {1'b0, k[15:3]};
	// only status is answered while busy; other reads drive zero
	always_comb begin
		rd_bit = 1'b0;
		if (bit_cnt >= hdr && bit_cnt >= OPCODE_BITS) begin
			case (opcode)
				STATUS_ONE_READ_CMD: rd_bit = pick(status_byte, k);
				PROT_CONFIG_READ_CMD: rd_bit = !busy_out && pick(k[3] ? prot_config[15:8] : prot_config[7:0], k);
				VOLATILE_LOCK_READ_CMD: rd_bit = !busy_out && pick(vol_lock[sector(addr)], k);
				PERSISTENT_LOCK_READ_CMD: rd_bit = !busy_out && pick(pers_lock[sector(addr)], k);
				ONETIME_READ_CMD: rd_bit = !busy_out && otp_sum[13:OTP_ADDR_W] == 4'h0
					&& addr[23:OTP_ADDR_W] == 14'h0 && pick(otp_mem[otp_sum[OTP_ADDR_W-1:0]], k);
				default: rd_bit = 1'b0;
			endcase
		end
	end

	// data leaves on the falling edge after its bit index is reached
	always_ff @(posedge clk_in or negedge rstn) begin
		if (!rstn) begin
			so_out <= 1'b0;
			so_oe_out <= 1'b0;
			suspend_refused_out <= 1'b0;
		end else begin
			so_oe_out <= ~pin.cs_n;
			if (cs_fall) begin
				so_out <= 1'b0;
			end else if (sck_fall) begin
				so_out <= rd_bit;
			end
			suspend_refused_out <= sck_rise && bit_cnt == OPCODE_BITS - 16'h0001
				&& {opcode[6:0], pin.si} == ERASE_SUSPEND_CMD && op == OP_ERASE;
		end
	end

	a_wel_gates_start: assert property (@(posedge clk_in) disable iff (!rstn) $rose(busy_out) |-> $past(write_enable_latch))
		else $error("write started without write enable latch");
	// busy length counted apart from the timer
	always_ff @(posedge clk_in or negedge rstn) begin
		if (!rstn) begin
			busy_run <= '0;
		end else begin
			busy_run <= busy_out ? busy_run + TIMER_W'(1) : '0;
		end
	end
	a_prog_busy_len: assert property (@(posedge clk_in) disable iff (!rstn)
		$fell(busy_out) && $past(op) != OP_ERASE |-> busy_run == TIMER_W'(PROGRAM_CYCLES))
		else $error("program busy time wrong");
	a_wel_clear_end: assert property (@(posedge clk_in) disable iff (!rstn) $fell(busy_out) |-> !write_enable_latch)
		else $error("write enable latch not cleared at end");
	a_otp_lock_err: assert property (@(posedge clk_in) disable iff (!rstn)
		done && op == OP_OTP && pin.otp_lock && !(&page_buf) |=> p_err)
		else $error("locked zero program gave no error");
	a_otp_ones_ok: assert property (@(posedge clk_in) disable iff (!rstn)
		done && op == OP_OTP && (&page_buf) |=> !p_err)
		else $error("programming ones reported an error");
	a_erase_ones: assert property (@(posedge clk_in) disable iff (!rstn)
		done && op == OP_ERASE |=> pers_lock[0] == LOCK_ERASED && pers_lock[SECTORS-1] == LOCK_ERASED)
		else $error("persistent erase left programmed bits");
	a_suspend_erase: assert property (@(posedge clk_in) disable iff (!rstn)
		suspend_refused_out |-> busy_out && op == OP_ERASE)
		else $error("suspend refusal outside persistent erase");
	a_config_len: assert property (@(posedge clk_in) disable iff (!rstn)
		$rose(busy_out) && op == OP_ASP |-> $past(bit_cnt) == LEN_PROT_CONFIG)
		else $error("config program started at wrong bit count");
	a_otp_range: assert property (@(posedge clk_in) disable iff (!rstn)
		$rose(busy_out) && op == OP_OTP |-> $past(addr[23:OTP_ADDR_W]) == 14'h0)
		else $error("one-time program outside region");
	a_so_on_fall: assert property (@(posedge clk_in) disable iff (!rstn)
		$changed(so_out) |-> $past(sck_fall) || $past(cs_fall))
		else $error("serial output moved off a falling edge");
endmodule

// ### dv/spi_host_model.sv
/* Host serial controller model: one frame of opcode and data out, then data in, mode 0.
   Assumes the bench clock on clk_in; pins change on its falling edge, sck at 64 ns. */
`timescale 1ns/100ps
module spi_host_model (
	input wire logic clk_in, // bench clock
	input wire logic so_in, // device serial out
	output logic cs_n_out, // chip select, active low
	output logic sck_out, // serial clock, idle low
	output logic si_out // serial data to device
);
	initial begin
		cs_n_out = 1'b1;
		sck_out = 1'b0;
		si_out = 1'b1;
	end
	task automatic half();
		repeat (8) @(negedge clk_in);
	endtask
	// n_tx bits of tx sent msb first, then n_rx bits captured at rising sck
	task automatic frame(input logic [47:0] tx, input int n_tx, input int n_rx, output logic [31:0] rx);
		rx = '0;
		@(negedge clk_in);
		cs_n_out = 1'b0;
		for (int i = 0; i < n_tx + n_rx; i++) begin
			// no meaning in si during the read phase, so it carries noise
			si_out = (i < n_tx) ? tx[n_tx - 1 - i] : 1'($urandom);
			half();
			sck_out = 1'b1;
			if (i >= n_tx)
				rx = {rx[30:0], so_in};
			half();
			sck_out = 1'b0;
		end
		half();
		cs_n_out = 1'b1;
		si_out = ~si_out;
		repeat (12) @(negedge clk_in);
	endtask
endmodule

// ### dv/tb_flash_prot_cmds.sv
/* Self-checking bench for flash_prot_cmds with a host model and a byte-array reference.
   Assumes the erase time is shortened to 200 clocks; run ends via results. */
`timescale 1ns/100ps
module tb_flash_prot_cmds;
	import flash_prot_pkg::*;
	logic clk_in = 1'b0;
	logic rstn_in = 1'b0;
	logic otp_lock_in = 1'b0;
	logic cs_n, sck, si, so_out, so_oe_out, busy_out, suspend_refused_out;
	int error_cnt = 0;
	int n_checks = 0;
	int refusals = 0;
	logic [15:0] cfg = 16'hFFFF;
	logic [7:0] vol [256];
	logic [7:0] pers [256];
	logic [7:0] otp [1024];
	logic perr = 1'b0;
	logic oe_ok = 1'b1;
	logic [31:0] rx;
	logic [15:0] d;
	logic [7:0] s;
	logic [9:0] a;
	always #2 clk_in = ~clk_in;
	always @(negedge clk_in)
		if (suspend_refused_out === 1'b1)
			refusals++;
	// while sck is high the select has long settled, so the enable must be up
	always @(negedge clk_in)
		if (cs_n === 1'b0 && sck === 1'b1 && so_oe_out !== 1'b1)
			oe_ok = 1'b0;
	flash_prot_cmds #(.ERASE_CYCLES_P(200)) uut (.clk_in(clk_in), .rstn_in(rstn_in), .cs_n_in(cs_n),
		.sck_in(sck), .si_in(si), .otp_lock_in(otp_lock_in), .so_out(so_out), .so_oe_out(so_oe_out),
		.busy_out(busy_out), .suspend_refused_out(suspend_refused_out));
	spi_host_model host (.clk_in(clk_in), .so_in(so_out), .cs_n_out(cs_n), .sck_out(sck), .si_out(si));
	task automatic results();
		$display("checks %0d errors %0d", n_checks, error_cnt);
		if (error_cnt == 0 && n_checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
		n_checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("wrong value t=%0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
		n_checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("wrong value t=%0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic poll(input logic write_enable_latch);
		logic [31:0] r;
		int k;
		for (k = 0; k < 40; k++) begin
			host.frame({40'h0, STATUS_ONE_READ_CMD}, 8, 8, r);
			if (r[WIP_BIT] === 1'b0)
				break;
		end
		if (k == 40) begin
			error_cnt++;
			results();
		end
		// a poll that straddles the end of the operation can mix old and new bits
		host.frame({40'h0, STATUS_ONE_READ_CMD}, 8, 8, r);
		chk8(r[7:0], {1'b0, perr, 4'h0, write_enable_latch, 1'b0});
	endtask
	// write enable first unless en is 0; eb < 0 skips the busy look
	task automatic wr(input logic [47:0] tx, input int n, input bit en, input int eb);
		logic [31:0] r;
		if (en)
			host.frame({40'h0, WRITE_ENABLE_CMD}, 8, 0, r);
		host.frame(tx, n, 0, r);
		if (eb >= 0)
			chk8({7'h0, busy_out}, 8'(eb));
	endtask
	task automatic rdcfg();
		host.frame({40'h0, PROT_CONFIG_READ_CMD}, 8, 32, rx);
		chk16(rx[31:16], {cfg[7:0], cfg[15:8]});
		chk16(rx[15:0], {cfg[7:0], cfg[15:8]});
	endtask
	task automatic rdlock(input logic [7:0] op, input logic [7:0] sec, input logic [7:0] exp);
		host.frame({8'h0, op, 8'h00, sec, 16'h0000}, 40, 16, rx);
		chk8(rx[15:8], exp);
		chk8(rx[7:0], exp);
	endtask
	task automatic otp_rd(input logic [9:0] adr);
		host.frame({16'h0, ONETIME_READ_CMD, 14'h0, adr}, 32, 24, rx);
		chk8(rx[15:8], otp[adr]);
		chk8(rx[7:0], otp[adr + 10'h1]);
	endtask
	initial begin
		repeat (100000) @(posedge clk_in);
		error_cnt++;
		results();
	end
	initial begin
		void'($urandom(32'hC0D866E8));
		for (int i = 0; i < 1024; i++) begin
			otp[i] = OTP_ERASED;
			if (i < 256) begin
				vol[i] = LOCK_ERASED;
				pers[i] = LOCK_ERASED;
			end
		end
		repeat (8) @(negedge clk_in);
		rstn_in = 1'b1;
		repeat (10) @(negedge clk_in);
		rdcfg();
		d = 16'($urandom);
		wr({24'h0, PROT_CONFIG_PROGRAM_CMD, d[7:0], d[15:8]}, 24, 1, 1);
		cfg = cfg & d;
		poll(1'b0);
		rdcfg();
		wr({24'h0, PROT_CONFIG_PROGRAM_CMD, 16'h0}, 24, 0, 0);
		poll(1'b0);
		wr({24'h0, PROT_CONFIG_PROGRAM_CMD, 16'h0} >> 1, 23, 1, 0);
		poll(1'b1);
		rdcfg();
		for (int j = 0; j < 2; j++) begin
			s = 8'($urandom);
			d = 16'($urandom);
			wr({VOLATILE_LOCK_WRITE_CMD, 8'h00, s, 16'h0000, d[7:0]}, 48, 1, 1);
			vol[s] = d[7:0];
			poll(1'b0);
			rdlock(VOLATILE_LOCK_READ_CMD, s, vol[s]);
			rdlock(VOLATILE_LOCK_READ_CMD, s + 8'h1, vol[s + 8'h1]);
		end
		wr({8'h0, PERSISTENT_LOCK_PROGRAM_CMD, 8'h00, s, 16'h0000}, 40, 1, 1);
		pers[s] = LOCK_PROGRAMMED;
		poll(1'b0);
		rdlock(PERSISTENT_LOCK_READ_CMD, s, pers[s]);
		wr({40'h0, PERSISTENT_LOCK_ERASE_CMD}, 8, 1, 1);
		host.frame({40'h0, ERASE_SUSPEND_CMD}, 8, 0, rx);
		chk8(8'(refusals), 8'h01);
		poll(1'b0);
		rdlock(PERSISTENT_LOCK_READ_CMD, s, LOCK_ERASED);
		a = 10'($urandom % 1023);
		for (int j = 0; j < 2; j++) begin
			d = 16'($urandom) | 16'h00F0;
			wr({8'h0, ONETIME_PROGRAM_CMD, 14'h0, a, d[7:0]}, 40, 1, 1);
			otp[a] = otp[a] & d[7:0];
			poll(1'b0);
		end
		otp_rd(a);
		wr({8'h0, ONETIME_PROGRAM_CMD, 14'h1, a, 8'h00}, 40, 1, 0);
		poll(1'b1);
		otp_rd(a);
		otp_lock_in = 1'b1;
		wr({8'h0, ONETIME_PROGRAM_CMD, 14'h0, a, 8'hFF}, 40, 1, -1);
		poll(1'b0);
		wr({8'h0, ONETIME_PROGRAM_CMD, 14'h0, a, 8'h00}, 40, 1, -1);
		perr = 1'b1;
		poll(1'b0);
		otp_rd(a);
		chk8({6'h0, oe_ok, so_oe_out}, 8'h02);
		results();
	end
endmodule
